// *** hdl/clock_ratio_control.v ***
// Clock ratio control: APB register file, ratio apply and aux clock pin
`timescale 1ns/1ns
`include "clock_ratio_defs.vh"

module clock_ratio_control
(
	// Clock and power-on reset
	input wire CLOCK_IN,
	input wire RESET_IN,
	// APB slave
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [11:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	input wire [3:0] PSTRB_IN,
	output wire [31:0] PRDATA_OUT,
	output wire PREADY_OUT,
	output wire PSLVERR_OUT,
	// Watchdog settling handshake
	input wire WDT_OVERFLOW_IN,
	output wire WDT_START_OUT,
	// Applied ratios to the clock tree
	output wire [2:0] PLL_MULT_OUT,
	output wire [2:0] CORE_DIV_OUT,
	output wire [2:0] PERIPH_DIV_OUT,
	output wire CLOCKS_RUN_OUT,
	output wire CPU_HALT_OUT,
	// Auxiliary clock pin
	output wire AUX_CLOCK_PIN_OUT,
	output wire AUX_CLOCK_PIN_OE_OUT
);

	localparam ST_RUN = 2'b01;
	localparam ST_SETTLE = 2'b10;
	// Power-on field values
	localparam [15:0] RATIO_INIT = `RATIO_RESET;
	localparam [2:0] MULT_INIT = {RATIO_INIT[`B_MULT_HI], RATIO_INIT[`B_MULT_MID],
		RATIO_INIT[`B_MULT_LO]};
	localparam [2:0] CORE_INIT = {RATIO_INIT[`B_CORE_HI], RATIO_INIT[`B_CORE_MID],
		RATIO_INIT[`B_CORE_LO]};
	localparam [2:0] PER_INIT = {RATIO_INIT[`B_PER_HI], RATIO_INIT[`B_PER_MID],
		RATIO_INIT[`B_PER_LO]};

	// Programmed fields
	reg [2:0] mult_sel_q;
	reg [2:0] core_sel_q;
	reg [2:0] per_sel_q;
	reg aux_clock_tristate_q;
	// Applied fields
	reg [2:0] mult_run_q;
	reg [2:0] core_run_q;
	reg [2:0] per_run_q;
	reg [1:0] state_q;
	reg [1:0] state_d;
	// Bus answer
	reg [31:0] prdata_q;
	reg pready_q;
	reg pslverr_q;
	// Outputs
	reg [2:0] pll_mult_q;
	reg [2:0] core_div_q;
	reg [2:0] periph_div_q;
	reg clocks_run_q;
	reg cpu_halt_q;
	reg wdt_start_q;
	reg aux_clk_q;
	reg aux_oe_q;

	wire sel_ratio;
	wire sel_aux;
	wire word_ok;
	wire access;
	wire do_write;
	wire [2:0] w_mult;
	wire [2:0] w_core;
	wire [2:0] w_per;
	wire mult_change;
	reg [15:0] ratio_rd;
	reg [2:0] mult_val;
	reg [2:0] core_val;
	reg [2:0] per_val;

	assign sel_ratio = (PADDR_IN == `OFS_RATIO);
	assign sel_aux = (PADDR_IN == `OFS_AUX);
	// R1 word access only
	assign word_ok = (PSTRB_IN == `STRB_WORD) || !PWRITE_IN;
	assign access = PSEL_IN && PENABLE_IN;
	assign do_write = access && pready_q && PWRITE_IN && word_ok && (sel_ratio || sel_aux);

	// R3 multiplier field gather
	assign w_mult = {PWDATA_IN[`B_MULT_HI], PWDATA_IN[`B_MULT_MID], PWDATA_IN[`B_MULT_LO]};
	// R4 core divider field gather
	assign w_core = {PWDATA_IN[`B_CORE_HI], PWDATA_IN[`B_CORE_MID], PWDATA_IN[`B_CORE_LO]};
	// R5 peripheral divider field gather
	assign w_per = {PWDATA_IN[`B_PER_HI], PWDATA_IN[`B_PER_MID], PWDATA_IN[`B_PER_LO]};
	assign mult_change = do_write && sel_ratio && (w_mult != mult_sel_q);

	// Read image of the ratio register
	always @*
	begin
		ratio_rd = 16'h0000;
		// R6 reserved bits read zero
		// R7 fixed bit reads one
		ratio_rd[`B_FIXED_ONE] = 1'b1;
		ratio_rd[`B_MULT_HI] = mult_sel_q[2];
		ratio_rd[`B_MULT_MID] = mult_sel_q[1];
		ratio_rd[`B_MULT_LO] = mult_sel_q[0];
		ratio_rd[`B_CORE_HI] = core_sel_q[2];
		ratio_rd[`B_CORE_MID] = core_sel_q[1];
		ratio_rd[`B_CORE_LO] = core_sel_q[0];
		ratio_rd[`B_PER_HI] = per_sel_q[2];
		ratio_rd[`B_PER_MID] = per_sel_q[1];
		ratio_rd[`B_PER_LO] = per_sel_q[0];
	end

	// APB answer, one wait state
	always @(posedge CLOCK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else if (access && !pready_q)
		begin
			pready_q <= 1'b1;
			pslverr_q <= !(sel_ratio || sel_aux) || !word_ok;
			if (!PWRITE_IN && sel_ratio)
			begin
				prdata_q <= {16'h0000, ratio_rd};
			end
			else if (!PWRITE_IN && sel_aux)
			begin
				// R17 upper bits read zero
				prdata_q <= {31'h0000_0000, aux_clock_tristate_q};
			end
			else
			begin
				prdata_q <= 32'h0000_0000;
			end
		end
		else
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// Programmed registers
	always @(posedge CLOCK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			// R2 power-on value
			mult_sel_q <= MULT_INIT;
			core_sel_q <= CORE_INIT;
			per_sel_q <= PER_INIT;
			// R17 reset drives the pin
			aux_clock_tristate_q <= `AUX_RESET;
		end
		else if (do_write && sel_ratio)
		begin
			// R16 no second PLL control
			// R20 codes stored as written
			mult_sel_q <= w_mult;
			core_sel_q <= w_core;
			per_sel_q <= w_per;
		end
		else if (do_write && sel_aux)
		begin
			// R17 tri-state select
			aux_clock_tristate_q <= PWDATA_IN[`B_AUX_TRI];
		end
	end

	// Apply sequencer
	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_RUN:
			begin
				// R19 multiplier change halts
				if (mult_change)
				begin
					state_d = ST_SETTLE;
				end
			end
			ST_SETTLE:
			begin
				// R19 resume on watchdog overflow
				if (WDT_OVERFLOW_IN)
				begin
					state_d = ST_RUN;
				end
			end
			default:
			begin
				state_d = ST_RUN;
			end
		endcase
	end

	always @(posedge CLOCK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			state_q <= ST_RUN;
			// R2 power-on ratios applied
			mult_run_q <= MULT_INIT;
			core_run_q <= CORE_INIT;
			per_run_q <= PER_INIT;
			wdt_start_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			wdt_start_q <= (state_q == ST_RUN) && mult_change;
			if (state_q == ST_RUN && !mult_change)
			begin
				// R18 divider change at once
				core_run_q <= core_sel_q;
				per_run_q <= per_sel_q;
				mult_run_q <= mult_sel_q;
			end
			else if (state_q == ST_SETTLE && WDT_OVERFLOW_IN)
			begin
				// R19 new ratios after settling
				mult_run_q <= mult_sel_q;
				core_run_q <= core_sel_q;
				per_run_q <= per_sel_q;
			end
		end
	end

	// Code to ratio decode
	always @*
	begin
		// R8 multiplier value
		case (mult_run_q)
			`CODE_1: mult_val = 3'd1;
			`CODE_2: mult_val = 3'd2;
			`CODE_3: mult_val = 3'd3;
			`CODE_4: mult_val = 3'd4;
			`CODE_6: mult_val = 3'd6;
			default: mult_val = 3'd0;
		endcase
		case (core_run_q)
			`CODE_1: core_val = 3'd1;
			`CODE_2: core_val = 3'd2;
			`CODE_3: core_val = 3'd3;
			`CODE_4: core_val = 3'd4;
			default: core_val = 3'd0;
		endcase
		// R9 peripheral divisor value
		case (per_run_q)
			`CODE_1: per_val = 3'd1;
			`CODE_2: per_val = 3'd2;
			`CODE_3: per_val = 3'd3;
			`CODE_4: per_val = 3'd4;
			`CODE_6: per_val = 3'd6;
			default: per_val = 3'd0;
		endcase
	end

	// Registered outputs and aux pin
	always @(posedge CLOCK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			pll_mult_q <= 3'd0;
			core_div_q <= 3'd0;
			periph_div_q <= 3'd0;
			clocks_run_q <= 1'b0;
			cpu_halt_q <= 1'b0;
			aux_clk_q <= 1'b0;
			aux_oe_q <= 1'b0;
		end
		else
		begin
			pll_mult_q <= mult_val;
			core_div_q <= core_val;
			periph_div_q <= per_val;
			// R19 clocks stop while settling
			clocks_run_q <= (state_d == ST_RUN);
			cpu_halt_q <= (state_d == ST_SETTLE);
			aux_clk_q <= !aux_clk_q;
			// R17 pin enable
			aux_oe_q <= !aux_clock_tristate_q;
		end
	end

	assign PRDATA_OUT = prdata_q;
	assign PREADY_OUT = pready_q;
	assign PSLVERR_OUT = pslverr_q;
	assign WDT_START_OUT = wdt_start_q;
	assign PLL_MULT_OUT = pll_mult_q;
	assign CORE_DIV_OUT = core_div_q;
	assign PERIPH_DIV_OUT = periph_div_q;
	assign CLOCKS_RUN_OUT = clocks_run_q;
	assign CPU_HALT_OUT = cpu_halt_q;
	assign AUX_CLOCK_PIN_OUT = aux_clk_q;
	assign AUX_CLOCK_PIN_OE_OUT = aux_oe_q;

endmodule // clock_ratio_control

// *** hdl/clock_ratio_defs.vh ***
// Constants for the clock ratio control block
// Contract
// R1 - Ratio register is 16 bits; only word-sized accesses are accepted.
// R2 - Power-on reset loads 0x0102; manual reset and standby keep it.
// R3 - Multiplier field bits 15,5,4: 000 x1, 001 x2, 100 x3, 010 x4, 101 x6.
// R4 - Core divider field bits 14,3,2: 000 /1, 001 /2, 100 /3, 010 /4.
// R5 - Peripheral divider bits 13,1,0: 000 /1, 001 /2, 100 /3, 010 /4, 101 /6.
// R6 - Bits 12 to 9, 7 and 6 read zero; software writes zero.
// R7 - Bit 8 reads one; software writes one.
// R8 - PLL output equals bus clock pin frequency times selected multiplier.
// R9 - Peripheral clock is bus clock times multiplier divided by peripheral divider.
// R10 - Software keeps peripheral clock within 6 to 33.34 MHz, not above bus clock.
// R11 - With USB in use, software keeps peripheral clock at 13 MHz or more.
// R12 - Software keeps core clock 24-100 MHz or 24-160 MHz per speed grade.
// R13 - Software keeps bus clock 24-50 MHz or 24-66.64 MHz per speed grade.
// R14 - Software never makes the core clock slower than the bus clock pin.
// R15 - Software never lets PLL output exceed the rated processor frequency.
// R16 - Second PLL state follows the clock mode; no register bit controls it.
// R17 - Aux control bit 0: 0 drives aux clock pin, 1 tri-states; others zero.
// R18 - Divider-only changes take effect at once, with no settling pause.
// R19 - Multiplier change halts CPU, stops clocks until watchdog overflow.
// R20 - Only listed encodings are legal; others give undefined clocks.
`ifndef CLOCK_RATIO_DEFS_VH
`define CLOCK_RATIO_DEFS_VH

// Register byte offsets
`define OFS_RATIO 12'h000
`define OFS_AUX 12'h004

// Reset values
`define RATIO_RESET 16'h0102
`define AUX_RESET 1'b0

// Field bit positions in the ratio and aux registers
`define B_MULT_HI 15
`define B_MULT_MID 5
`define B_MULT_LO 4
`define B_CORE_HI 14
`define B_CORE_MID 3
`define B_CORE_LO 2
`define B_PER_HI 13
`define B_PER_MID 1
`define B_PER_LO 0
`define B_FIXED_ONE 8
`define B_AUX_TRI 0

// Field codes {hi,mid,lo}
`define CODE_1 3'h0
`define CODE_2 3'h1
`define CODE_3 3'h4
`define CODE_4 3'h2
`define CODE_6 3'h5

// Word-size byte strobe pattern
`define STRB_WORD 4'h3

`endif

// *** test/cr_chk_asserts.sv ***
// Assertions on the clock ratio control ports
`timescale 1ns/1ns
module cr_chk
(
	// Clock and reset
	input wire CLOCK_IN,
	input wire RESET_IN,
	// Bus
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [11:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	input wire [3:0] PSTRB_IN,
	input wire PREADY_OUT,
	input wire PSLVERR_OUT,
	// Clock tree
	input wire WDT_OVERFLOW_IN,
	input wire WDT_START_OUT,
	input wire [2:0] PLL_MULT_OUT,
	input wire CLOCKS_RUN_OUT,
	input wire CPU_HALT_OUT,
	input wire AUX_CLOCK_PIN_OE_OUT
);
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (RESET_IN);
	wire done = PSEL_IN && PENABLE_IN && PREADY_OUT;
	rdy_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("ready held");
	rdy_wait_a: assert property ($rose(PENABLE_IN) && PSEL_IN |=> PREADY_OUT)
		else $error("ready late");
	strb_err_a: assert property (done && PWRITE_IN && PSTRB_IN != 4'h3 |-> PSLVERR_OUT)
		else $error("strobe not refused");
	halt_enter_a: assert property (WDT_START_OUT |-> CPU_HALT_OUT && !CLOCKS_RUN_OUT)
		else $error("no halt");
	halt_exit_a: assert property (CPU_HALT_OUT && WDT_OVERFLOW_IN |=> !CPU_HALT_OUT)
		else $error("no resume");
	halt_hold_a: assert property (
		CPU_HALT_OUT && !WDT_OVERFLOW_IN |=> CPU_HALT_OUT && $stable(PLL_MULT_OUT))
		else $error("halt broken");
	start_once_a: assert property (WDT_START_OUT |=> !WDT_START_OUT [*2])
		else $error("start repeated");
	oe_follow_a: assert property (
		done && PWRITE_IN && PADDR_IN == 12'h004 && PSTRB_IN == 4'h3
		|-> ##2 AUX_CLOCK_PIN_OE_OUT != $past(PWDATA_IN[0], 2)) else $error("oe wrong");
	cover property (done && PWRITE_IN);
	cover property (WDT_START_OUT);
	cover property (PSLVERR_OUT && PREADY_OUT);
endmodule // cr_chk
bind clock_ratio_control cr_chk chk (.CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN),
	.PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
	.PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .WDT_OVERFLOW_IN(WDT_OVERFLOW_IN),
	.WDT_START_OUT(WDT_START_OUT), .PLL_MULT_OUT(PLL_MULT_OUT),
	.CLOCKS_RUN_OUT(CLOCKS_RUN_OUT), .CPU_HALT_OUT(CPU_HALT_OUT),
	.AUX_CLOCK_PIN_OE_OUT(AUX_CLOCK_PIN_OE_OUT));

// *** test/tb_clock_ratio_control.sv ***
// Self-checking bench for the clock ratio control block
`timescale 1ns/1ns
module tb_clock_ratio_control;
	reg CLOCK_IN = 0, RESET_IN = 1, PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0;
	reg WDT_OVERFLOW_IN = 0;
	reg [11:0] PADDR_IN = '0;
	reg [31:0] PWDATA_IN = '0;
	reg [3:0] PSTRB_IN = '0;
	wire [31:0] PRDATA_OUT;
	wire PREADY_OUT, PSLVERR_OUT, WDT_START_OUT, CLOCKS_RUN_OUT, CPU_HALT_OUT;
	wire AUX_CLOCK_PIN_OUT, AUX_CLOCK_PIN_OE_OUT;
	wire [2:0] PLL_MULT_OUT, CORE_DIV_OUT, PERIPH_DIV_OUT;
	int miscompares = 0, tests_run = 0, i;
	reg [31:0] r, w;
	reg e;
	reg [2:0] cd [0:4] = '{3'h0, 3'h1, 3'h4, 3'h2, 3'h5};
	reg [2:0] vl [0:4] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
	clock_ratio_control dut
	(
		.CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN),
		.PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
		.PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN),
		.PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
		.WDT_OVERFLOW_IN(WDT_OVERFLOW_IN), .WDT_START_OUT(WDT_START_OUT),
		.PLL_MULT_OUT(PLL_MULT_OUT), .CORE_DIV_OUT(CORE_DIV_OUT),
		.PERIPH_DIV_OUT(PERIPH_DIV_OUT), .CLOCKS_RUN_OUT(CLOCKS_RUN_OUT),
		.CPU_HALT_OUT(CPU_HALT_OUT), .AUX_CLOCK_PIN_OUT(AUX_CLOCK_PIN_OUT),
		.AUX_CLOCK_PIN_OE_OUT(AUX_CLOCK_PIN_OE_OUT)
	);
	always #5 CLOCK_IN = ~CLOCK_IN;
	function [31:0] mk(input [2:0] m, c, p);
		mk = {16'h0000, m[2], c[2], p[2], 4'h0, 1'b1, 2'b00, m[1:0], c[1:0], p[1:0]};
	endfunction
	task ck(input [31:0] s, x);
		begin
			tests_run++;
			if (s !== x)
			begin
				miscompares++;
				$display("Error %0t: got %h want %h", $time, s, x);
			end
		end
	endtask
	task apb(input wr, input [11:0] a, input [31:0] d, input [3:0] s);
		begin
			@(posedge CLOCK_IN);
			PSEL_IN <= 1'b1;
			PWRITE_IN <= wr;
			PADDR_IN <= a;
			PWDATA_IN <= d;
			PSTRB_IN <= s;
			@(posedge CLOCK_IN);
			PENABLE_IN <= 1'b1;
			@(posedge CLOCK_IN);
			while (PREADY_OUT !== 1'b1)
				@(posedge CLOCK_IN);
			r = PRDATA_OUT;
			e = PSLVERR_OUT;
			PSEL_IN <= 1'b0;
			PENABLE_IN <= 1'b0;
		end
	endtask
	task settle;
		begin
			repeat (2) @(posedge CLOCK_IN);
			@(negedge CLOCK_IN);
		end
	endtask
	task t_mult;
		for (i = 1; i <= 5; i++)
		begin
			apb(1, 12'h000, mk(cd[i % 5], cd[i % 5 % 4], cd[i % 5]), 4'h3);
			@(negedge CLOCK_IN);
			ck(WDT_START_OUT, 1'b1);
			ck(CPU_HALT_OUT, 1'b1);
			ck(CLOCKS_RUN_OUT, 1'b0);
			ck(PLL_MULT_OUT, vl[i - 1]);
			@(posedge CLOCK_IN) WDT_OVERFLOW_IN <= 1'b1;
			@(posedge CLOCK_IN) WDT_OVERFLOW_IN <= 1'b0;
			settle;
			ck(CLOCKS_RUN_OUT, 1'b1);
			ck(CPU_HALT_OUT, 1'b0);
			ck(PLL_MULT_OUT, vl[i % 5]);
			ck(CORE_DIV_OUT, vl[i % 5 % 4]);
			ck(PERIPH_DIV_OUT, vl[i % 5]);
		end
	endtask
	task t_regs;
		begin
			apb(1, 12'h000, 32'h0000_0111, 4'h1);
			ck(e, 1'b1);
			apb(0, 12'h000, 32'h0000_0000, 4'h3);
			ck(r, 32'h0000_0100);
			apb(1, 12'h000, 32'h0000_1EC2, 4'h3);
			apb(0, 12'h000, 32'h0000_0000, 4'h3);
			ck(r, 32'h0000_0102);
			apb(0, 12'h008, 32'h0000_0000, 4'h3);
			ck(e, 1'b1);
			ck(r, 32'h0000_0000);
		end
	endtask
	task t_divs;
		for (i = 0; i < 5; i++)
		begin
			// x1 with core /1 keeps clocks legal
			w = mk(3'h0, 3'h0, cd[i]);
			apb(1, 12'h000, w, 4'h3);
			settle;
			ck(CORE_DIV_OUT, vl[0]);
			ck(PERIPH_DIV_OUT, vl[i]);
			ck(CLOCKS_RUN_OUT, 1'b1);
			apb(0, 12'h000, 32'h0000_0000, 4'h3);
			ck(r, w);
		end
	endtask
	task t_aux;
		for (i = 0; i < 2; i++)
		begin
			apb(1, 12'h004, i == 0 ? 32'h0000_FFFF : 32'h0000_0000, 4'h3);
			apb(0, 12'h004, 32'h0000_0000, 4'h3);
			ck(r, i == 0 ? 32'h0000_0001 : 32'h0000_0000);
			w[0] = AUX_CLOCK_PIN_OUT;
			@(negedge CLOCK_IN);
			ck(AUX_CLOCK_PIN_OUT, !w[0]);
			ck(AUX_CLOCK_PIN_OE_OUT, i != 0);
		end
	endtask
	task t_reset;
		begin
			apb(1, 12'h004, 32'h0000_0001, 4'h3);
			@(posedge CLOCK_IN) RESET_IN <= 1'b1;
			repeat (2) @(posedge CLOCK_IN);
			RESET_IN <= 1'b0;
			apb(0, 12'h000, 32'h0000_0000, 4'h3);
			ck(r, 32'h0000_0102);
			ck(PERIPH_DIV_OUT, 3'h4);
			apb(0, 12'h004, 32'h0000_0000, 4'h3);
			ck(r, 32'h0000_0000);
			ck(AUX_CLOCK_PIN_OE_OUT, 1'b1);
		end
	endtask
	task wrap_up;
		begin
			$display("tests %0d errors %0d", tests_run, miscompares);
			if (miscompares == 0 && tests_run > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	initial
	begin
		repeat (5) @(posedge CLOCK_IN);
		RESET_IN <= 1'b0;
		apb(0, 12'h000, 32'h0000_0000, 4'h3);
		ck(r, 32'h0000_0102);
		ck(PERIPH_DIV_OUT, 3'h4);
		t_mult;
		t_regs;
		t_divs;
		t_aux;
		t_reset;
		wrap_up;
	end
	initial
	begin
		#50000;
		miscompares++;
		wrap_up;
	end
endmodule // tb_clock_ratio_control
